// *** src/twp_top.sv ***
// Purpose: Sequences one function cycle of typewheel positioning and print strike
// Assumes: code_ready pulses once per received combination with code stable that cycle
// Notes: Combinations that arrive mid-cycle are dropped and flagged in missed_code
`timescale 1ns/100ps
`default_nettype none
`include "twp_defines.svh"

module twp_top (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Code from selector stage
    input wire logic code_ready,
    input wire logic [`TWP_CODE_W-1:0] code,
    input wire logic code_is_function,
    // Positioning
    output logic rot_ccw,
    output logic [`TWP_ROW_W-1:0] row_count,
    output logic [`TWP_CHAR_W-1:0] char_index,
    output logic positioning,
    // Print and status
    output logic strike,
    output logic strike_latched,
    output logic busy,
    output logic missed_code
);

    localparam twp_pkg::twp_cnt_t SENSE_CYC = `TWP_CNT_W'(`TWP_SENSE_CYC);
    localparam twp_pkg::twp_cnt_t HALF_CYC = `TWP_CNT_W'(`TWP_HALF_CYC);
    localparam twp_pkg::twp_cnt_t CNT_ONE = `TWP_CNT_W'(1);

    twp_sel_if sel ();

    twp_pkg::twp_state_e state;
    twp_pkg::twp_state_e next_state;
    twp_pkg::twp_cnt_t cnt;
    twp_pkg::twp_cnt_t next_cnt;
    twp_pkg::twp_code_t held_code;
    logic held_function;

    twp_decode u_decode (
        .clk(clk),
        .reset(reset),
        .sel(sel.dec)
    );

    assign sel.code = held_code;

    // Phase decode
    wire logic in_idle = (state == twp_pkg::TWP_IDLE);
    wire logic cnt_done = (cnt == CNT_ONE);
    wire logic take_code = in_idle && code_ready;
    wire logic drop_code = !in_idle && code_ready;
    wire logic enter_position = (state == twp_pkg::TWP_SENSE) && cnt_done;
    wire logic enter_strike = (state == twp_pkg::TWP_POSITION) && cnt_done;
    wire logic in_return = (state == twp_pkg::TWP_STRIKE) || (state == twp_pkg::TWP_RETURN);
    wire logic fire = enter_strike && !held_function;

    // Sequencer: sense delay, first half positioning, midpoint, second half return
    always_comb begin
        next_state = state;
        next_cnt = cnt - CNT_ONE;
        unique case (state)
            twp_pkg::TWP_IDLE: begin
                next_cnt = SENSE_CYC;
                if (code_ready) begin
                    next_state = twp_pkg::TWP_SENSE;
                end
            end
            twp_pkg::TWP_SENSE: begin
                if (cnt_done) begin
                    next_state = twp_pkg::TWP_POSITION;
                    next_cnt = HALF_CYC;
                end
            end
            twp_pkg::TWP_POSITION: begin
                if (cnt_done) begin
                    next_state = twp_pkg::TWP_STRIKE;
                    next_cnt = HALF_CYC;
                end
            end
            twp_pkg::TWP_STRIKE: begin
                next_state = twp_pkg::TWP_RETURN;
            end
            twp_pkg::TWP_RETURN: begin
                if (cnt_done) begin
                    next_state = twp_pkg::TWP_LATCH;
                end
            end
            twp_pkg::TWP_LATCH: begin
                next_state = twp_pkg::TWP_IDLE;
                next_cnt = SENSE_CYC;
            end
            default: begin
                next_state = twp_pkg::TWP_IDLE;
                next_cnt = SENSE_CYC;
            end
        endcase
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state <= twp_pkg::TWP_IDLE;
            cnt <= `TWP_CNT_W'(0);
        end else begin
            state <= next_state;
            cnt <= next_cnt;
        end
    end

    // Code held for the whole cycle so the selector may start the next one
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            held_code <= `TWP_CODE_RST;
            held_function <= 1'b0;
        end else if (take_code) begin
            held_code <= code;
            held_function <= code_is_function;
        end
    end

    // Position outputs: loaded on entry to positioning, cleared once positioning ends
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rot_ccw <= 1'b0;
            row_count <= `TWP_ROW_RST;
            char_index <= `TWP_CHAR_RST;
            positioning <= 1'b0;
        end else if (enter_position) begin
            rot_ccw <= sel.ccw;
            row_count <= sel.rows;
            char_index <= sel.char_sel;
            positioning <= 1'b1;
        end else if (enter_strike || in_return || in_idle) begin
            rot_ccw <= 1'b0;
            row_count <= `TWP_ROW_RST;
            char_index <= `TWP_CHAR_RST;
            positioning <= 1'b0;
        end
    end

    // Strike pulse at the midpoint; latch re-armed only at end of cycle
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            strike <= 1'b0;
            strike_latched <= 1'b1;
        end else begin
            strike <= fire;
            if (fire) begin
                strike_latched <= 1'b0;
            end else if (state == twp_pkg::TWP_LATCH) begin
                strike_latched <= 1'b1;
            end
        end
    end

    // Busy covers the whole cycle; missed_code holds until the next accepted code clears it
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            busy <= 1'b0;
            missed_code <= 1'b0;
        end else begin
            busy <= (next_state != twp_pkg::TWP_IDLE);
            if (drop_code) begin
                missed_code <= 1'b1;
            end else if (take_code) begin
                missed_code <= 1'b0;
            end
        end
    end

endmodule // twp_top

`default_nettype wire

// *** src/twp_defines.svh ***
// Purpose: Timing, width and code-bit position constants for the typewheel decoder
// Assumes: 250 MHz clock; code bit n of the combination sits at index n-1
// Notes: Function cycle length and sense delay are chosen defaults; retune per mechanism
`ifndef TWP_DEFINES_SVH
`define TWP_DEFINES_SVH

`define TWP_CLK_MHZ 250
`define TWP_CODE_W 8
`define TWP_ROW_W 4
`define TWP_CHAR_W 2
`define TWP_CNT_W 10

// Code bit positions
`define TWP_BIT_SHIFT 0
`define TWP_BIT_ROW2 1
`define TWP_BIT_ROW3 2
`define TWP_BIT_DIR 3
`define TWP_BIT_VERT5 4
`define TWP_BIT_VERT7 6

// Rows reached at each stop, odd field before the shift adds one
`define TWP_ROWS_COMMON 4'h1
`define TWP_ROWS_STOP3 4'h3
`define TWP_ROWS_STOP2 4'h5
`define TWP_ROWS_SHIFT 4'h7

// Whole function cycle and the delay from reception to its start
`define TWP_CYCLE_NS 2000
`define TWP_SENSE_NS 40
`define TWP_HALF_CYC ((`TWP_CYCLE_NS * `TWP_CLK_MHZ) / 2000)
`define TWP_SENSE_CYC (((`TWP_SENSE_NS * `TWP_CLK_MHZ) + 999) / 1000)

// Reset values
`define TWP_ROW_RST 4'h0
`define TWP_CHAR_RST 2'h0
`define TWP_CODE_RST 8'h00

`endif

// *** src/twp_pkg.sv ***
// Purpose: Types shared by the typewheel decoder modules
// Assumes: Constants come from twp_defines.svh
// Notes: Sequencer states are Gray coded from TWP_IDLE to TWP_LATCH; the return to TWP_IDLE changes all three bits
`default_nettype none
`include "twp_defines.svh"

package twp_pkg;

    typedef logic [`TWP_CODE_W-1:0] twp_code_t;
    typedef logic [`TWP_ROW_W-1:0] twp_row_t;
    typedef logic [`TWP_CHAR_W-1:0] twp_char_t;
    typedef logic [`TWP_CNT_W-1:0] twp_cnt_t;

    typedef enum logic [2:0] {
        TWP_IDLE     = 3'h0,
        TWP_SENSE    = 3'h1,
        TWP_POSITION = 3'h3,
        TWP_STRIKE   = 3'h2,
        TWP_RETURN   = 3'h6,
        TWP_LATCH    = 3'h7
    } twp_state_e;

endpackage

`default_nettype wire

// *** src/twp_sel_if.sv ***
// Purpose: Carries the held code and its decoded position between sequencer and decoder
// Assumes: One clock domain
// Notes: Decoder results are registered
`timescale 1ns/100ps
`default_nettype none
`include "twp_defines.svh"

interface twp_sel_if;
    twp_pkg::twp_code_t code;
    logic ccw;
    twp_pkg::twp_row_t rows;
    twp_pkg::twp_char_t char_sel;

    modport dec (
        input code,
        output ccw,
        output rows,
        output char_sel
    );

    modport seq (
        output code,
        input ccw,
        input rows,
        input char_sel
    );
endinterface

`default_nettype wire

// *** src/twp_decode.sv ***
// Purpose: Turns a held code combination into direction, row count and character index
// Assumes: Code is stable at least one clock before results are used
// Notes: Rotation walks the stops in travel order and halts at the first blocking one
`timescale 1ns/100ps
`default_nettype none
`include "twp_defines.svh"

module twp_decode (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Selection carrier
    twp_sel_if.dec sel
);

    // Stop walk: common, bit-3, bit-2, then shift which always blocks
    function automatic twp_pkg::twp_row_t twp_rows(input twp_pkg::twp_code_t c);
        twp_pkg::twp_row_t base;
        if (!(c[`TWP_BIT_ROW2] || c[`TWP_BIT_ROW3])) begin
            base = `TWP_ROWS_COMMON;
        end else if (!c[`TWP_BIT_ROW3]) begin
            base = `TWP_ROWS_STOP3;
        end else if (!c[`TWP_BIT_ROW2]) begin
            base = `TWP_ROWS_STOP2;
        end else begin
            base = `TWP_ROWS_SHIFT;
        end
        // Marking shift moves every stop back one row
        twp_rows = base + {3'h0, c[`TWP_BIT_SHIFT]};
    endfunction

    wire twp_pkg::twp_row_t next_rows = twp_rows(sel.code);
    wire logic next_ccw = sel.code[`TWP_BIT_DIR];
    wire twp_pkg::twp_char_t next_char =
        {sel.code[`TWP_BIT_VERT5], sel.code[`TWP_BIT_VERT7]};

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sel.ccw <= 1'b0;
            sel.rows <= `TWP_ROW_RST;
            sel.char_sel <= `TWP_CHAR_RST;
        end else begin
            sel.ccw <= next_ccw;
            sel.rows <= next_rows;
            sel.char_sel <= next_char;
        end
    end

endmodule // twp_decode

`default_nettype wire

// *** dv/twp_checker.sv ***
// Purpose: Port assertions for twp_top
// Assumes: Sense 10 cycles, half cycle 250 cycles
// Notes: Fields rebuilt from code seen 11 edges back
`timescale 1ns/100ps
`default_nettype none
`include "twp_defines.svh"
module twp_checker (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Selector side
    input wire logic code_ready,
    input wire logic [`TWP_CODE_W-1:0] code,
    input wire logic code_is_function,
    // Watched outputs
    input wire logic rot_ccw,
    input wire logic [`TWP_ROW_W-1:0] row_count,
    input wire logic [`TWP_CHAR_W-1:0] char_index,
    input wire logic positioning,
    input wire logic strike,
    input wire logic strike_latched,
    input wire logic busy,
    input wire logic missed_code
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    logic fn_held;
    wire logic take;
    assign take = code_ready && !busy;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) fn_held <= 1'h0;
        else if (take) fn_held <= code_is_function;
    end
    property p_start;
        take |=> busy ##9 !positioning ##1 positioning;
    endproperty
    a_start: assert property (p_start) else $error("start late");
    property p_rows;
        take |-> ##11 row_count == ({1'h0, $past(code[2:0], 11)} + 4'h1);
    endproperty
    a_rows: assert property (p_rows) else $error("rows wrong");
    property p_dir;
        take |-> ##11 rot_ccw == $past(code[3], 11);
    endproperty
    a_dir: assert property (p_dir) else $error("direction wrong");
    property p_char;
        take |-> ##11 char_index == {$past(code[4], 11), $past(code[6], 11)};
    endproperty
    a_char: assert property (p_char) else $error("char wrong");
    property p_idle;
        !positioning |-> (row_count == 4'h0 && char_index == 2'h0 && !rot_ccw);
    endproperty
    a_idle: assert property (p_idle) else $error("idle not zero");
    property p_range;
        positioning |-> (row_count != 4'h0 && row_count <= 4'h8);
    endproperty
    a_range: assert property (p_range) else $error("row out of range");
    property p_hold;
        $rose(positioning) |-> ##249 positioning ##1 !positioning;
    endproperty
    a_hold: assert property (p_hold) else $error("half length");
    property p_strike;
        $fell(positioning) |-> strike == !fn_held;
    endproperty
    a_strike: assert property (p_strike) else $error("strike wrong");
    property p_pulse;
        strike |=> !strike && !strike_latched;
    endproperty
    a_pulse: assert property (p_pulse) else $error("strike pulse");
    property p_relatch;
        $fell(strike_latched) |-> ##251 (strike_latched && !busy);
    endproperty
    a_relatch: assert property (p_relatch) else $error("relatch");
    c_print: cover property (strike);
    c_func: cover property (take && code_is_function);
    c_miss: cover property (code_ready && busy);
endmodule // twp_checker
bind twp_top twp_checker i_chk (.clk(clk), .reset(reset), .code_ready(code_ready),
    .code(code), .code_is_function(code_is_function), .rot_ccw(rot_ccw),
    .row_count(row_count), .char_index(char_index), .positioning(positioning),
    .strike(strike), .strike_latched(strike_latched), .busy(busy), .missed_code(missed_code));
`default_nettype wire

// *** dv/twp_sel_model.sv ***
// Purpose: Selector stage offering one code per combination
// Assumes: Driven 1 ns after the rising edge
// Notes: Released lines show the inverse of the last value
`timescale 1ns/100ps
`default_nettype none
`include "twp_defines.svh"
module twp_sel_model (
    // Clock
    input wire logic clk,
    // Code out
    output logic code_ready,
    output logic [`TWP_CODE_W-1:0] code,
    output logic code_is_function
);
    initial begin
        code_ready = 1'h0;
        code = `TWP_CODE_RST;
        code_is_function = 1'h0;
    end
    task automatic send(input logic [7:0] c, input logic fn);
        @(posedge clk);
        #1;
        code_ready = 1'h1;
        code = c;
        code_is_function = fn;
        @(posedge clk);
        #1;
        code_ready = 1'h0;
        code = ~c;
        code_is_function = ~fn;
    endtask
endmodule // twp_sel_model
`default_nettype wire

// *** dv/typewheel_position_decoder_tb.sv ***
// Purpose: Self-checking bench for twp_top
// Assumes: Sense delay and half cycle as set in twp_defines.svh
// Notes: Decode rules also watched by the bound checker
`timescale 1ns/100ps
`default_nettype none
`include "twp_defines.svh"
module typewheel_position_decoder_tb;
    logic clk = 1'h0;
    logic reset = 1'h1;
    wire logic code_ready;
    wire logic code_is_function;
    wire logic [7:0] code;
    logic rot_ccw, positioning, strike, strike_latched, busy, missed_code;
    logic [3:0] row_count;
    logic [1:0] char_index;
    int bad_count = 0;
    int tests_run = 0;
    int cycles = 0;
    int waited = 0;
    always #2 clk = ~clk;
    twp_sel_model i_model (.clk(clk), .code_ready(code_ready), .code(code),
        .code_is_function(code_is_function));
    twp_top i_dut (.clk(clk), .reset(reset), .code_ready(code_ready), .code(code),
        .code_is_function(code_is_function), .rot_ccw(rot_ccw), .row_count(row_count),
        .char_index(char_index), .positioning(positioning), .strike(strike),
        .strike_latched(strike_latched), .busy(busy), .missed_code(missed_code));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Bounded wait on positioning or busy
    task automatic wait_on(input logic on_busy, input logic lv);
        int n;
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (((on_busy ? busy : positioning) !== lv) && n < 600);
        waited = n;
        chk(8'(n < 600), 8'h01);
    endtask
    task automatic run_one(input logic [7:0] c, input logic fn);
        i_model.send(c, fn);
        wait_on(1'h0, 1'h1);
        chk(8'(waited), 8'(`TWP_SENSE_CYC));
        chk(rot_ccw, c[3]);
        chk(row_count, 8'(c[2:0]) + 8'h01);
        chk(char_index, {c[4], c[6]});
        wait_on(1'h0, 1'h0);
        chk(8'(waited), 8'(`TWP_HALF_CYC));
        chk(strike, !fn);
        chk(strike_latched, fn);
        chk(row_count, 8'h00);
        wait_on(1'h1, 1'h0);
        chk(8'(waited), 8'(`TWP_HALF_CYC + 1));
        chk(strike_latched, 1'h1);
    endtask
    task automatic t_reset;
        chk({rot_ccw, row_count, char_index, positioning}, 8'h00);
        chk(strike_latched, 1'h1);
        $display("test reset done");
    endtask
    task automatic t_rows;
        for (int i = 0; i < 16; i++) begin
            run_one({1'h0, i[1], 1'h0, i[2], i[3:0]}, 1'h0);
        end
        $display("test rows done");
    endtask
    task automatic t_chars;
        for (int v = 0; v < 4; v++) begin
            run_one({1'h0, v[0], 1'h0, v[1], 4'h9}, 1'h0);
        end
        $display("test chars done");
    endtask
    task automatic t_func;
        run_one(8'h0a, 1'h1);
        $display("test function done");
    endtask
    // Second code lands mid-cycle and is dropped
    task automatic t_missed;
        i_model.send(8'h05, 1'h0);
        repeat (20) @(posedge clk);
        i_model.send(8'h0f, 1'h0);
        wait_on(1'h1, 1'h0);
        chk(missed_code, 1'h1);
        run_one(8'h03, 1'h0);
        chk(missed_code, 1'h0);
        $display("test missed done");
    endtask
    // Reset lands in the first cycle of positioning; block must restart cleanly
    task automatic t_midreset;
        i_model.send(8'h1b, 1'h0);
        wait_on(1'h0, 1'h1);
        reset = 1'h1;
        @(posedge clk);
        #1;
        chk({rot_ccw, row_count, char_index, positioning}, 8'h00);
        chk({strike, busy, missed_code}, 8'h00);
        chk(strike_latched, 1'h1);
        reset = 1'h0;
        run_one(8'h1b, 1'h0);
        $display("test midreset done");
    endtask
    task automatic conclude;
        $display("tests_run %0d bad_count %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 30000) begin
            bad_count++;
            conclude();
        end
    end
    initial begin
        repeat (8) @(posedge clk);
        #1;
        reset = 1'h0;
        t_reset();
        t_rows();
        t_chars();
        t_func();
        t_missed();
        t_midreset();
        conclude();
    end
endmodule // typewheel_position_decoder_tb
`default_nettype wire
